// *** src/iec_top.v ***
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "iec_map.vh"
`default_nettype none

module iec_top (
  input  wire        i_clk,
  input  wire        i_rst_n,
  input  wire [7:0]  i_wb_adr,
  input  wire [31:0] i_wb_dat,
  input  wire [3:0]  i_wb_sel,
  input  wire        i_wb_we,
  input  wire        i_wb_cyc,
  input  wire        i_wb_stb,
  output reg  [31:0] o_wb_dat,
  output reg         o_wb_ack,
  input  wire        i_instr_end,
  input  wire        i_ldi_opt_clear,
  input  wire        i_return_from_service,
  input  wire [11:0] i_pc,
  input  wire        i_carry,
  input  wire        i_zero,
  input  wire        i_low_power,
  input  wire        i_port_a,
  input  wire        i_port_b,
  input  wire        i_port_c,
  input  wire        i_port_d,
  input  wire        i_port_e,
  input  wire        i_sync_serial_done,
  input  wire        i_timer_overflow_flag,
  input  wire        i_converter_done,
  input  wire        i_serial_byte_received,
  input  wire        i_serial_byte_sent,
  input  wire        i_reload_timer_overflow_flag,
  input  wire        i_compare_one_flag,
  input  wire        i_compare_two_flag,
  input  wire        i_compare_null_flag,
  output reg         o_entry,
  output reg  [11:0] o_vector,
  output reg         o_stack_push,
  output reg  [11:0] o_stack_data,
  output reg         o_stack_pop,
  output reg         o_carry,
  output reg         o_zero,
  output reg  [1:0]  o_mode,
  output reg         o_wake
);

  localparam [1:0] MODE_NORMAL = 2'h0;
  localparam [1:0] MODE_IRQ    = 2'h1;
  localparam [1:0] MODE_NMI    = 2'h2;

  reg        rst_s1_reg;
  reg        rst_n_reg;
  wire       rst_n;

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg  <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg  <= rst_s1_reg;
    end
  end
  assign rst_n = rst_n_reg;

  // Pin lines pass three stages; a change counts once stages two and three agree.
  reg  [5:0] pin_s1_reg;
  reg  [5:0] pin_s2_reg;
  reg  [5:0] pin_s3_reg;
  reg  [5:0] pin_reg;
  wire [5:0] pin_raw = {i_sync_serial_done, i_port_e, i_port_d, i_port_c, i_port_b, i_port_a};

  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_reg <= 6'h3F;
      pin_s2_reg <= 6'h3F;
      pin_s3_reg <= 6'h3F;
      pin_reg    <= 6'h3F;
    end else begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      pin_reg    <= (pin_s2_reg & pin_s3_reg) | (pin_reg & (pin_s2_reg ^ pin_s3_reg));
    end
  end

  reg  [7:0] option_reg;
  reg  [7:0] evt_en_reg;
  wire       src1_level_select  = option_reg[`IEC_BIT_SRC1_LEVEL];
  wire       src2_edge_polarity = option_reg[`IEC_BIT_SRC2_POL];
  wire       global_irq_enable  = option_reg[`IEC_BIT_GLOBAL_EN];

  // Wishbone slave with one wait-free answer cycle per access.
  wire       wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire       wb_wr  = wb_req & i_wb_we & i_wb_sel[0];
  reg  [31:0] rd_next;

  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      option_reg <= `IEC_OPT_RESET;
      evt_en_reg <= `IEC_EN_RESET;
    end else if (wb_wr) begin
      if (i_wb_adr == `IEC_ADDR_OPTION) begin
        option_reg <= i_wb_dat[7:0];
      end else if (i_wb_adr == `IEC_ADDR_EVT_ENABLE) begin
        evt_en_reg <= i_wb_dat[7:0];
      end
    end
  end

  reg  [1:0]  mode_reg;
  reg  [1:0]  prev_mode_reg;
  reg  [11:0] saved_pc_reg;

  always @* begin
    rd_next = 32'h0000_0000;
    if (i_wb_adr == `IEC_ADDR_EVT_ENABLE) begin
      rd_next = {24'h00_0000, evt_en_reg};
    end else if (i_wb_adr == `IEC_ADDR_STATUS) begin
      rd_next = {28'h000_0000, prev_mode_reg, mode_reg};
    end else if (i_wb_adr == `IEC_ADDR_ENTRY_PC) begin
      rd_next = {20'h0_0000, saved_pc_reg};
    end
  end

  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= wb_req;
      o_wb_dat <= wb_req ? rd_next : 32'h0000_0000;
    end
  end

  wire src4_line = (i_timer_overflow_flag        & evt_en_reg[`IEC_EN_TIMER])
                 | (i_converter_done             & evt_en_reg[`IEC_EN_CONV])
                 | (i_serial_byte_received       & evt_en_reg[`IEC_EN_RX])
                 | (i_serial_byte_sent           & evt_en_reg[`IEC_EN_TX]);
  wire src3_line = (i_reload_timer_overflow_flag & evt_en_reg[`IEC_EN_OVF])
                 | (i_compare_one_flag           & evt_en_reg[`IEC_EN_CP1])
                 | (i_compare_two_flag           & evt_en_reg[`IEC_EN_CP2])
                 | (i_compare_null_flag          & evt_en_reg[`IEC_EN_NULL]);
  // Pin lines are active low; any low pin of a group drives its source.
  wire src0_low  = ~pin_reg[2];
  wire src1_low  = ~pin_reg[0] | ~pin_reg[4] | ~pin_reg[5];
  wire src2_high = pin_reg[1] & pin_reg[3];
  wire src2_low  = ~(pin_reg[1] & pin_reg[3]);

  reg  src0_prev_reg;
  reg  src1_prev_reg;
  reg  src2_prev_reg;
  reg  nmi_latch_reg;
  reg  src1_latch_reg;
  reg  src2_latch_reg;

  wire fall0 = src0_low & ~src0_prev_reg;
  wire fall1 = src1_low & ~src1_prev_reg;
  // Polarity bit picks rising or falling.
  wire edge2 = src2_edge_polarity ? (src2_high & src2_prev_reg) : (src2_low & ~src2_prev_reg);

  wire mask_ok = global_irq_enable & (mode_reg == MODE_NORMAL);
  wire req1 = src1_level_select ? src1_low : src1_latch_reg;
  wire req2 = src2_latch_reg;
  wire take0 = nmi_latch_reg & (mode_reg != MODE_NMI);
  wire take1 = ~take0 & mask_ok & req1;
  wire take2 = ~take0 & mask_ok & ~req1 & req2;
  wire take3 = ~take0 & mask_ok & ~req1 & ~req2 & src3_line;
  wire take4 = ~take0 & mask_ok & ~req1 & ~req2 & ~src3_line & src4_line;
  wire accept = i_instr_end & (take0 | take1 | take2 | take3 | take4);

  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      src0_prev_reg  <= 1'b0;
      src1_prev_reg  <= 1'b0;
      src2_prev_reg  <= 1'b0;
      nmi_latch_reg  <= 1'b0;
      src1_latch_reg <= 1'b0;
      src2_latch_reg <= 1'b0;
    end else begin
      src0_prev_reg <= src0_low;
      src1_prev_reg <= src1_low;
      src2_prev_reg <= src2_polarity_prev(src2_edge_polarity, src2_high, src2_low);
      // Flip-flop cleared at its own entry; a new edge wins.
      if (fall0) begin
        nmi_latch_reg <= 1'b1;
      end else if (accept & take0) begin
        nmi_latch_reg <= 1'b0;
      end
      // One stored edge, cleared at entry; level mode stores nothing.
      if (fall1 & ~src1_level_select) begin
        src1_latch_reg <= 1'b1;
      end else if ((accept & take1) | src1_level_select) begin
        src1_latch_reg <= 1'b0;
      end
      if (edge2) begin
        src2_latch_reg <= 1'b1;
      end else if (accept & take2) begin
        src2_latch_reg <= 1'b0;
      end
    end
  end

  function src2_polarity_prev;
    input pol;
    input hi;
    input lo;
    begin
      src2_polarity_prev = pol ? ~hi : lo;
    end
  endfunction

  // Option-clear load tracking; the core pulses at the load's first cycle.
  reg  [2:0] ldi_cnt_reg;
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ldi_cnt_reg <= 3'h0;
    end else if (i_ldi_opt_clear) begin
      ldi_cnt_reg <= 3'h1;
    end else if (ldi_cnt_reg != 3'h0 && ldi_cnt_reg != `IEC_LDI_CYCLES) begin
      ldi_cnt_reg <= ldi_cnt_reg + 3'h1;
    end else begin
      ldi_cnt_reg <= 3'h0;
    end
  end
  wire ldi_early = i_ldi_opt_clear |
                   (ldi_cnt_reg != 3'h0 && ldi_cnt_reg < `IEC_LDI_QUIRK_CYCLES);

  reg  [1:0] flags_norm_reg;
  reg  [1:0] flags_irq_reg;
  reg  [1:0] flags_nmi_reg;
  reg  [1:0] quirk_bank_reg;
  wire [1:0] cur_flags = {i_carry, i_zero};
  reg  [11:0] vec_next;

  always @* begin
    vec_next = `IEC_VEC_SRC4;
    if (take0) begin
      vec_next = `IEC_VEC_SRC0;
    end else if (take1) begin
      vec_next = `IEC_VEC_SRC1;
    end else if (take2) begin
      vec_next = `IEC_VEC_SRC2;
    end else if (take3) begin
      vec_next = `IEC_VEC_SRC3;
    end
  end

  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg       <= MODE_NORMAL;
      prev_mode_reg  <= MODE_NORMAL;
      saved_pc_reg   <= 12'h000;
      flags_norm_reg <= 2'h0;
      flags_irq_reg  <= 2'h0;
      flags_nmi_reg  <= 2'h0;
      quirk_bank_reg <= MODE_NORMAL;
      o_entry        <= 1'b0;
      o_vector       <= 12'h000;
      o_stack_push   <= 1'b0;
      o_stack_data   <= 12'h000;
      o_stack_pop    <= 1'b0;
      o_carry        <= 1'b0;
      o_zero         <= 1'b0;
      o_mode         <= MODE_NORMAL;
      o_wake         <= 1'b0;
    end else begin
      o_entry      <= 1'b0;
      o_stack_push <= 1'b0;
      o_stack_pop  <= 1'b0;
      o_wake       <= i_low_power & global_irq_enable &
                      (nmi_latch_reg | req1 | req2 | src3_line | src4_line);
      if (accept) begin
        prev_mode_reg <= mode_reg;
        // Current pair is banked under the mode being left, or under the normal pair after a quirk entry.
        if (quirk_bank_reg == MODE_IRQ || mode_reg == MODE_NORMAL) begin
          flags_norm_reg <= cur_flags;
        end else if (mode_reg == MODE_IRQ) begin
          flags_irq_reg <= cur_flags;
        end
        o_stack_push <= 1'b1;
        o_stack_data <= i_pc;
        saved_pc_reg <= i_pc;
        o_entry  <= 1'b1;
        o_vector <= vec_next;
        if (take0) begin
          mode_reg       <= MODE_NMI;
          o_mode         <= MODE_NMI;
          quirk_bank_reg <= MODE_NORMAL;
          {o_carry, o_zero} <= flags_nmi_reg;
        end else if (ldi_early) begin
          // Silicon quirk: normal pair stays active.
          mode_reg       <= MODE_IRQ;
          o_mode         <= MODE_IRQ;
          quirk_bank_reg <= MODE_IRQ;
          {o_carry, o_zero} <= cur_flags;
        end else begin
          mode_reg       <= MODE_IRQ;
          o_mode         <= MODE_IRQ;
          quirk_bank_reg <= MODE_NORMAL;
          {o_carry, o_zero} <= flags_irq_reg;
        end
      end else if (i_return_from_service && mode_reg != MODE_NORMAL) begin
        o_stack_pop <= 1'b1;
        mode_reg    <= prev_mode_reg;
        o_mode      <= prev_mode_reg;
        prev_mode_reg <= MODE_NORMAL;
        quirk_bank_reg <= MODE_NORMAL;
        if (mode_reg == MODE_NMI) begin
          flags_nmi_reg <= cur_flags;
        end else if (quirk_bank_reg == MODE_IRQ) begin
          flags_norm_reg <= cur_flags;
        end else begin
          flags_irq_reg <= cur_flags;
        end
        if (prev_mode_reg == MODE_IRQ) begin
          {o_carry, o_zero} <= flags_irq_reg;
        end else begin
          // A quirk entry kept the normal pair live, so that live pair is what resumes.
          {o_carry, o_zero} <= (quirk_bank_reg == MODE_IRQ) ? cur_flags : flags_norm_reg;
        end
      end
    end
  end

endmodule

`default_nettype wire

// *** src/iec_map.vh ***
`ifndef IEC_MAP_VH
`define IEC_MAP_VH

`define IEC_ADDR_OPTION      8'hC8
`define IEC_ADDR_EVT_ENABLE  8'hC9
`define IEC_ADDR_STATUS      8'hCA
`define IEC_ADDR_ENTRY_PC    8'hCB
`define IEC_OPT_RESET        8'h00
`define IEC_EN_RESET         8'h00
`define IEC_BIT_SRC1_LEVEL   6
`define IEC_BIT_SRC2_POL     5
`define IEC_BIT_GLOBAL_EN    4
`define IEC_EN_TIMER         0
`define IEC_EN_CONV          1
`define IEC_EN_RX            2
`define IEC_EN_TX            3
`define IEC_EN_OVF           4
`define IEC_EN_CP1           5
`define IEC_EN_CP2           6
`define IEC_EN_NULL          7
`define IEC_VEC_SRC0         12'hFFC
`define IEC_VEC_SRC1         12'hFF6
`define IEC_VEC_SRC2         12'hFF4
`define IEC_VEC_SRC3         12'hFF2
`define IEC_VEC_SRC4         12'hFF0
`define IEC_LDI_CYCLES       3'h4
`define IEC_LDI_QUIRK_CYCLES 3'h3

`endif

// *** tb/iec_checker_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "iec_map.vh"
module iec_checker (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic [7:0]  i_wb_adr,
  input wire logic        i_wb_we,
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  input wire logic        i_instr_end,
  input wire logic        i_return_from_service,
  input wire logic        o_entry,
  input wire logic [11:0] o_vector,
  input wire logic        o_stack_push,
  input wire logic        o_stack_pop,
  input wire logic [1:0]  o_mode
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  sequence s_taken;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  sequence s_answer;
    o_wb_ack ##1 !o_wb_ack;
  endsequence
  a_bus_answer: assert property (s_taken |=> s_answer)
    else $error("bus answer missing");
  a_option_unread: assert property (o_wb_ack && !$past(i_wb_we) &&
    $past(i_wb_adr) == `IEC_ADDR_OPTION |-> o_wb_dat == 32'h0)
    else $error("option register read back");
  a_data_idle: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
    else $error("read data outside ack");
  a_entry_push: assert property (o_entry || o_stack_push |-> o_entry && o_stack_push)
    else $error("push not with entry");
  a_entry_sample: assert property (o_entry |-> $past(i_instr_end))
    else $error("entry without instruction end");
  a_nmi_vector: assert property (o_entry && o_mode == 2'h2 |-> o_vector == `IEC_VEC_SRC0)
    else $error("wrong top priority vector");
  a_mask_block: assert property (o_entry && $past(o_mode) != 2'h0 |-> o_mode == 2'h2)
    else $error("maskable entry during service");
  a_pop_cause: assert property (o_stack_pop |->
    $past(i_return_from_service) && $past(o_mode) != 2'h0)
    else $error("pop without return");
  a_mode_step: assert property ($changed(o_mode) |-> o_entry || o_stack_pop)
    else $error("mode changed on its own");
endmodule
bind iec_top iec_checker u_iec_checker (.i_clk, .i_rst_n, .i_wb_adr, .i_wb_we, .i_wb_cyc,
  .i_wb_stb, .o_wb_dat, .o_wb_ack, .i_instr_end, .i_return_from_service, .o_entry,
  .o_vector, .o_stack_push, .o_stack_pop, .o_mode);
`default_nettype wire

// *** tb/iec_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module iec_core_model #(
  parameter logic [11:0] HOME_PC = 12'h100
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_entry,
  input  wire logic        i_stack_push,
  input  wire logic        i_stack_pop,
  input  wire logic [11:0] i_vector,
  input  wire logic [11:0] i_stack_data,
  input  wire logic        i_carry,
  input  wire logic        i_zero,
  output logic             o_instr_end,
  output logic [11:0]      o_pc,
  output logic             o_carry,
  output logic             o_zero
);
  logic [11:0] stk0_reg;
  logic [11:0] stk1_reg;
  // Two levels are kept so a top priority entry can nest over a maskable one.
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_instr_end <= 1'b0;
      o_pc <= HOME_PC;
      o_carry <= 1'b1;
      o_zero <= 1'b1;
      stk0_reg <= 12'h000;
      stk1_reg <= 12'h000;
    end else begin
      o_instr_end <= !o_instr_end;
      if (i_stack_push) begin
        stk0_reg <= i_stack_data;
        stk1_reg <= stk0_reg;
      end else if (i_stack_pop) begin
        o_pc <= stk0_reg;
        stk0_reg <= stk1_reg;
      end
      if (i_entry)
        o_pc <= i_vector;
      if (i_entry || i_stack_pop) begin
        o_carry <= i_carry;
        o_zero <= i_zero;
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/iec_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "iec_map.vh"
module iec_tb_top;
  logic        clk, rst_n, cyc, stb, we, ldi, ret, lowp;
  logic [3:0]  sel, lanes;
  logic [7:0]  adr, evt;
  logic [5:0]  pin_n;
  logic [31:0] dat, rd;
  wire         ack, ent_p, push, pop, carry, zero, wake, iend, c_core, z_core;
  wire  [31:0] rdat;
  wire  [11:0] vec, sdat, pc;
  wire  [1:0]  mode;
  int          error_cnt, checks_done, cyc_cnt;
  iec_top u_iec_top (.i_clk(clk), .i_rst_n(rst_n), .i_wb_adr(adr), .i_wb_dat(dat),
    .i_wb_sel(sel), .i_wb_we(we), .i_wb_cyc(cyc), .i_wb_stb(stb), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_instr_end(iend), .i_ldi_opt_clear(ldi), .i_return_from_service(ret),
    .i_pc(pc), .i_carry(c_core), .i_zero(z_core), .i_low_power(lowp), .i_port_a(pin_n[0]),
    .i_port_b(pin_n[3]), .i_port_c(pin_n[5]), .i_port_d(pin_n[4]), .i_port_e(pin_n[1]),
    .i_sync_serial_done(pin_n[2]), .i_timer_overflow_flag(evt[0]), .i_converter_done(evt[1]),
    .i_serial_byte_received(evt[2]), .i_serial_byte_sent(evt[3]),
    .i_reload_timer_overflow_flag(evt[4]), .i_compare_one_flag(evt[5]),
    .i_compare_two_flag(evt[6]), .i_compare_null_flag(evt[7]), .o_entry(ent_p),
    .o_vector(vec), .o_stack_push(push), .o_stack_data(sdat), .o_stack_pop(pop),
    .o_carry(carry), .o_zero(zero), .o_mode(mode), .o_wake(wake));
  iec_core_model u_iec_core_model (.i_clk(clk), .i_rst_n(rst_n), .i_entry(ent_p),
    .i_stack_push(push), .i_stack_pop(pop), .i_vector(vec), .i_stack_data(sdat),
    .i_carry(carry), .i_zero(zero), .o_instr_end(iend), .o_pc(pc), .o_carry(c_core),
    .o_zero(z_core));
  task automatic give_verdict;
    if (error_cnt == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    {cyc, stb, we, sel, adr, dat} <= {2'h3, w, lanes, a, 24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    rd = rdat;
    {cyc, stb} <= 2'h0;
  endtask
  task automatic none(input int n);
    repeat (n) begin
      @(posedge clk);
      chk("idle", ent_p, 1'b0);
    end
  endtask
  task automatic ent(input logic [11:0] v, input logic [1:0] m, input logic [11:0] sp,
                     input logic [1:0] cz);
    #1;
    for (int i = 0; i < 40 && ent_p !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk("entry", push, 1'b1);
    chk("vector", vec, v);
    chk("mode", mode, m);
    chk("pushed", sdat, sp);
    chk("flags", {carry, zero}, cz);
    @(posedge clk);
  endtask
  task automatic rt(input logic [1:0] m);
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
    #1;
    chk("pop", pop, 1'b1);
    chk("mode", mode, m);
    if (m == 2'h0) chk("flags", {carry, zero}, 2'h3);
    @(posedge clk);
  endtask
  task automatic s_regs;
    wb(1'b0, `IEC_ADDR_EVT_ENABLE, 8'h00);
    chk("enables", rd, 32'h0);
    wb(1'b1, `IEC_ADDR_EVT_ENABLE, 8'h01);
    evt[0] <= 1'b1;
    none(10);
    evt <= 8'h00;
    wb(1'b1, `IEC_ADDR_OPTION, 8'h70);
    wb(1'b0, `IEC_ADDR_OPTION, 8'h00);
    chk("option", rd, 32'h0);
    wb(1'b1, 8'hD0, 8'hFF);
    wb(1'b0, 8'hD0, 8'h00);
    chk("unmapped", rd, 32'h0);
    lanes <= 4'h0;
    wb(1'b1, `IEC_ADDR_EVT_ENABLE, 8'hFF);
    lanes <= 4'hF;
    wb(1'b0, `IEC_ADDR_EVT_ENABLE, 8'h00);
    chk("lane", rd, 32'h1);
  endtask
  task automatic s_events;
    wb(1'b1, `IEC_ADDR_OPTION, 8'h10);
    for (int k = 0; k < 8; k++) begin
      wb(1'b1, `IEC_ADDR_EVT_ENABLE, ~(8'h01 << k));
      evt[k] <= 1'b1;
      none(6);
      wb(1'b1, `IEC_ADDR_EVT_ENABLE, 8'h01 << k);
      ent(k < 4 ? `IEC_VEC_SRC4 : `IEC_VEC_SRC3, 2'h1, 12'h100, 2'h0);
      evt <= 8'h00;
      rt(2'h0);
    end
  endtask
  task automatic s_pins;
    for (int k = 0; k < 6; k++) begin
      pin_n[k] <= 1'b0;
      ent(k < 3 ? `IEC_VEC_SRC1 : k < 5 ? `IEC_VEC_SRC2 : `IEC_VEC_SRC0,
          k == 5 ? 2'h2 : 2'h1, 12'h100, 2'h0);
      pin_n[k] <= 1'b1;
      none(8);
      rt(2'h0);
    end
    pin_n[0] <= 1'b0;
    ent(`IEC_VEC_SRC1, 2'h1, 12'h100, 2'h0);
    pin_n[0] <= 1'b1;
    none(6);
    pin_n[0] <= 1'b0;
    none(8);
    rt(2'h0);
    ent(`IEC_VEC_SRC1, 2'h1, 12'h100, 2'h0);
    pin_n[0] <= 1'b1;
    none(8);
    rt(2'h0);
    wb(1'b1, `IEC_ADDR_OPTION, 8'h50);
    pin_n[0] <= 1'b0;
    ent(`IEC_VEC_SRC1, 2'h1, 12'h100, 2'h0);
    rt(2'h0);
    ent(`IEC_VEC_SRC1, 2'h1, 12'h100, 2'h0);
    pin_n[0] <= 1'b1;
    none(8);
    rt(2'h0);
    wb(1'b1, `IEC_ADDR_OPTION, 8'h30);
    pin_n[3] <= 1'b0;
    none(10);
    pin_n[3] <= 1'b1;
    ent(`IEC_VEC_SRC2, 2'h1, 12'h100, 2'h0);
    rt(2'h0);
  endtask
  task automatic s_power;
    wb(1'b1, `IEC_ADDR_OPTION, 8'h00);
    wb(1'b1, `IEC_ADDR_EVT_ENABLE, 8'h01);
    {lowp, evt[0]} <= 2'h3;
    none(10);
    pin_n[5] <= 1'b0;
    ent(`IEC_VEC_SRC0, 2'h2, 12'h100, 2'h0);
    chk("wake", wake, 1'b0);
    pin_n[5] <= 1'b1;
    none(8);
    rt(2'h0);
    wb(1'b1, `IEC_ADDR_OPTION, 8'h10);
    ent(`IEC_VEC_SRC4, 2'h1, 12'h100, 2'h0);
    chk("wake", wake, 1'b1);
    lowp <= 1'b0;
    pin_n[5] <= 1'b0;
    ent(`IEC_VEC_SRC0, 2'h2, `IEC_VEC_SRC4, 2'h0);
    wb(1'b0, `IEC_ADDR_STATUS, 8'h00);
    chk("status", rd, 32'h6);
    wb(1'b0, `IEC_ADDR_ENTRY_PC, 8'h00);
    chk("saved pc", rd, 32'h0FF0);
    pin_n[5] <= 1'b1;
    none(8);
    rt(2'h1);
    evt <= 8'h00;
    rt(2'h0);
  endtask
  task automatic s_quirk;
    {ldi, evt[0]} <= 2'h3;
    @(posedge clk);
    ldi <= 1'b0;
    ent(`IEC_VEC_SRC4, 2'h1, 12'h100, 2'h3);
    evt <= 8'h00;
    rt(2'h0);
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 6000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    {rst_n, cyc, stb, we, ldi, ret, lowp} = 7'h00;
    {adr, evt, dat} = 48'h0;
    pin_n = 6'h3F;
    {sel, lanes} = 8'h0F;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    s_regs();
    s_events();
    s_pins();
    s_power();
    s_quirk();
    give_verdict();
  end
endmodule
`default_nettype wire
